/* logic/sfs_status_read.sv */
// serial status-read logic of the flash device
// Behaviour
// - a status-read command is taken at any time, also while a program or erase runs.
// - after the command byte one status bit is driven per serial clock, no dummy cycles.
// - after the second status byte the first follows again while select and clock continue.
// - status contents are sampled afresh for every repetition of the two bytes.
// - the ready/busy flag sits in both bytes and is sampled again for each byte.
// - above the status-read clock limit the first two returned bytes may be invalid.
// - releasing select ends the read and puts the serial output in high impedance.
// - select may be released at any bit position of the output.
// - bit 7 of status byte one is a read/write lock flag, 0 meaning unlocked, reset to 0.
// - when the lock flag is 1 the sector protection registers are treated as locked.
`timescale 1ns/100ps
`include "sfs_map.svh"
module sfs_status_read (
	input wire logic clk,
	input wire logic rst,
	input sfs_pkg::sfs_pins_t pins,
	input sfs_pkg::sfs_status_src_t status_src,
	input wire logic ready_busy_flag,
	input wire logic lock_wr_en,
	input wire logic lock_wr_data,
	output logic so_out,
	output logic so_oe_n,
	output logic protection_regs_locked
);
	import sfs_pkg::*;

	sfs_pins_t pins_s;
	sfs_state_t state;
	logic sck_d;
	logic sck_rise;
	logic sck_fall;
	logic [2:0] bit_cnt;
	logic [6:0] cmd_shift;
	logic [7:0] cmd_byte;
	logic [7:0] out_shift;
	logic byte_sel;
	logic [7:0] byte_one;
	logic [7:0] byte_two;
	logic [7:0] next_byte;
	logic load_now;

	sfs_sync #(.WIDTH(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(pins),
		.reset_val(3'h7),
		.sync_out(pins_s)
	);

	// pin edges seen by the system clock
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_d <= 1'b0;
		end else begin
			sck_d <= pins_s.sck;
		end
	end

	assign sck_rise = pins_s.sck & ~sck_d & ~pins_s.cs_n;
	assign sck_fall = ~pins_s.sck & sck_d & ~pins_s.cs_n;
	assign cmd_byte = {cmd_shift, pins_s.si};

	// live status contents, busy in both bytes
	assign byte_one = {protection_regs_locked, status_src.byte1_misc, ready_busy_flag};
	assign byte_two = {status_src.byte2_misc, ready_busy_flag};
	assign next_byte = byte_sel ? byte_two : byte_one;
	assign load_now = (state == ST_OUT) && sck_fall && (bit_cnt == `SFS_BIT_FIRST);

	// command sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else if (pins_s.cs_n) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					state <= ST_CMD;
				end
				ST_CMD: begin
					if (sck_rise && bit_cnt == `SFS_BIT_LAST) begin
						// taken regardless of busy
						if (cmd_byte == `SFS_CMD_READ_STATUS) begin
							state <= ST_OUT;
						end else begin
							state <= ST_SKIP;
						end
					end
				end
				ST_OUT: begin
					state <= ST_OUT;
				end
				ST_SKIP: begin
					state <= ST_SKIP;
				end
			endcase
		end
	end

	// bit counter: rising edges in command, falling edges in output
	always_ff @(posedge clk) begin
		if (rst || pins_s.cs_n || state == ST_IDLE) begin
			bit_cnt <= `SFS_BIT_FIRST;
		end else if ((state == ST_CMD && sck_rise) || (state == ST_OUT && sck_fall)) begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// command input shift
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_shift <= 7'h00;
		end else if (state == ST_CMD && sck_rise) begin
			cmd_shift <= cmd_byte[6:0];
		end
	end

	// byte alternation
	always_ff @(posedge clk) begin
		if (rst || state != ST_OUT) begin
			byte_sel <= 1'b0;
		end else if (sck_fall && bit_cnt == `SFS_BIT_LAST) begin
			byte_sel <= ~byte_sel;
		end
	end

	// output shift, fresh sample at each byte start; slow pin sync makes the
	// first pair stale only if the link outruns the sampling clock
	always_ff @(posedge clk) begin
		if (rst) begin
			out_shift <= 8'h00;
			so_out <= 1'b0;
		end else if (load_now) begin
			so_out <= next_byte[7];
			out_shift <= {next_byte[6:0], 1'b0};
		end else if (state == ST_OUT && sck_fall) begin
			so_out <= out_shift[7];
			out_shift <= {out_shift[6:0], 1'b0};
		end
	end

	// output enable, low while driving
	always_ff @(posedge clk) begin
		if (rst || pins_s.cs_n) begin
			so_oe_n <= 1'b1;
		end else if (load_now) begin
			so_oe_n <= 1'b0;
		end
	end

	// protection lock flag
	always_ff @(posedge clk) begin
		if (rst) begin
			protection_regs_locked <= `SFS_LOCK_RESET;
		end else if (lock_wr_en) begin
			protection_regs_locked <= lock_wr_data;
		end
	end

	a_release_tristate: assert property (@(posedge clk) disable iff (rst)
		pins_s.cs_n |=> so_oe_n && state == ST_IDLE)
		else $error("output still driven after select release");

	a_idle_not_driving: assert property (@(posedge clk) disable iff (rst)
		state == ST_IDLE |-> so_oe_n && bit_cnt == 3'h0)
		else $error("idle with output driven or count left");

	a_cmd_starts_out: assert property (@(posedge clk) disable iff (rst)
		(state == ST_CMD && sck_rise && bit_cnt == 3'h7 && cmd_byte == 8'h05)
		|=> state == ST_OUT)
		else $error("status command not taken");

	a_other_cmd_skip: assert property (@(posedge clk) disable iff (rst)
		(state == ST_CMD && sck_rise && bit_cnt == 3'h7 && cmd_byte != 8'h05)
		|=> state == ST_SKIP)
		else $error("foreign command answered");

	a_first_bit_msb: assert property (@(posedge clk) disable iff (rst)
		(load_now && !byte_sel && !pins_s.cs_n) |=> so_out == $past(byte_one[7]) && !so_oe_n)
		else $error("first bit is not msb of byte one");

	a_byte_wrap: assert property (@(posedge clk) disable iff (rst)
		(state == ST_OUT && sck_fall && bit_cnt == 3'h7 && !pins_s.cs_n)
		|=> byte_sel != $past(byte_sel))
		else $error("byte order did not alternate");

	a_busy_fresh: assert property (@(posedge clk) disable iff (rst)
		(load_now && !pins_s.cs_n) |=> out_shift[1] == $past(ready_busy_flag))
		else $error("busy not sampled at byte start");

	a_lock_write: assert property (@(posedge clk) disable iff (rst)
		lock_wr_en |=> protection_regs_locked == $past(lock_wr_data))
		else $error("lock flag write lost");

	a_lock_reset: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> !protection_regs_locked)
		else $error("lock flag not cleared by reset");

	a_out_holds: assert property (@(posedge clk) disable iff (rst)
		!(state == ST_OUT && sck_fall) |=> so_out == $past(so_out))
		else $error("serial output moved without a falling clock edge");

	a_cmd_quiet: assert property (@(posedge clk) disable iff (rst)
		state == ST_CMD |-> so_oe_n)
		else $error("output driven before the command byte ended");

	a_skip_silent: assert property (@(posedge clk) disable iff (rst)
		state == ST_SKIP |-> so_oe_n)
		else $error("output driven for a foreign command");

	a_byte_two_fresh: assert property (@(posedge clk) disable iff (rst)
		(load_now && byte_sel) |=> so_out == $past(status_src.byte2_misc[7])
		&& out_shift[7:1] == {$past(status_src.byte2_misc[6:1]), $past(ready_busy_flag)})
		else $error("byte two not sampled afresh");

	c_status_read: cover property (@(posedge clk) state == ST_CMD ##[1:200] state == ST_OUT);
	c_second_byte: cover property (@(posedge clk) load_now && byte_sel);
	c_mid_byte_stop: cover property (@(posedge clk)
		state == ST_OUT && bit_cnt == 3'h4 ##1 state == ST_IDLE);
	c_skip_cmd: cover property (@(posedge clk) state == ST_SKIP);
	c_busy_byte: cover property (@(posedge clk) load_now && ready_busy_flag);
endmodule : sfs_status_read

/* logic/sfs_map.svh */
// constants of the status-read serial logic
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
`define SFS_CMD_READ_STATUS 8'h05
`define SFS_LOCK_BIT 7
`define SFS_BUSY_BIT 0
`define SFS_LOCK_RESET 1'b0
`define SFS_BIT_LAST 3'h7
`define SFS_BIT_FIRST 3'h0
`define SFS_SYNC_STAGES 2
`endif

/* logic/sfs_pkg.sv */
// types of the status-read serial logic
package sfs_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_OUT,
		ST_SKIP
	} sfs_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sfs_pins_t;

	typedef struct packed {
		logic [6:1] byte1_misc;
		logic [7:1] byte2_misc;
	} sfs_status_src_t;
endpackage : sfs_pkg

/* logic/sfs_sync.sv */
// two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
module sfs_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					stage1[i] <= reset_val[i];
					sync_out[i] <= reset_val[i];
				end else begin
					stage1[i] <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule : sfs_sync

/* verification/sfs_host_model.sv */
// spi host model for the status-read logic
`timescale 1ns/100ps
module sfs_host_model (
	input wire logic clk,
	input wire logic so_out,
	input wire logic so_oe_n,
	output sfs_pkg::sfs_pins_t pins,
	output logic so_line
);
	import sfs_pkg::*;
	logic last_so = 1'h0;
	initial pins = 3'h4;
	always @(posedge clk) if (!so_oe_n) last_so <= so_out;
	// released line shows no stale value
	assign so_line = so_oe_n ? ~last_so : so_out;
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task xfer(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			pins.si = d[i];
			tick(4);
			pins.sck = 1'h1;
			tick(4);
			q[i] = so_line;
			pins.sck = 1'h0;
		end
	endtask : xfer
	task select(input logic [7:0] cmd);
		logic [7:0] q;
		pins.cs_n = 1'h0;
		tick(4);
		xfer(cmd, 8, q);
	endtask : select
	task release_cs();
		tick(4);
		pins.cs_n = 1'h1;
	endtask : release_cs
endmodule : sfs_host_model

/* verification/sfs_status_read_tb.sv */
// testbench of the serial status-read logic
`timescale 1ns/100ps
module sfs_status_read_tb;
	import sfs_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	sfs_pins_t pins;
	sfs_status_src_t status_src = '0;
	logic ready_busy_flag = 1'h0;
	logic lock_wr_en = 1'h0;
	logic lock_wr_data = 1'h0;
	logic so_out, so_oe_n, protection_regs_locked, so_line;
	int failures = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	sfs_status_read i_sfs_status_read (.clk(clk), .rst(rst), .pins(pins),
		.status_src(status_src), .ready_busy_flag(ready_busy_flag),
		.lock_wr_en(lock_wr_en), .lock_wr_data(lock_wr_data), .so_out(so_out),
		.so_oe_n(so_oe_n), .protection_regs_locked(protection_regs_locked));
	sfs_host_model i_sfs_host_model (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n),
		.pins(pins), .so_line(so_line));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task finish_test();
		$display("checked %0d, failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task write_lock(input logic d);
		@(posedge clk) #1;
		lock_wr_en = 1'h1;
		lock_wr_data = d;
		@(posedge clk) #1;
		lock_wr_en = 1'h0;
		check({7'h0, protection_regs_locked}, {7'h0, d});
	endtask : write_lock
	task end_frame();
		int n;
		i_sfs_host_model.release_cs();
		n = 0;
		while (so_oe_n !== 1'h1 && n < 20) begin
			@(posedge clk) #1;
			n++;
		end
		check({7'h0, so_oe_n}, 8'h01);
		if (n == 20) finish_test();
	endtask : end_frame
	task test_stream();
		logic [7:0] q, exp, nxt;
		logic b;
		write_lock(1'h1);
		for (int k = 0; k <= 4; k++) begin
			status_src = {6'(k * 11 + 5), 7'(k * 37 + 3)};
			b = ~(k[0] ^ k[1]);
			ready_busy_flag = b;
			nxt = k[0] ? {status_src.byte2_misc, b} : {lock_wr_data, status_src.byte1_misc, b};
			if (k == 0) i_sfs_host_model.select(8'h05);
			else begin
				i_sfs_host_model.xfer(8'h55, 8, q);
				check(q, exp);
			end
			// hold the sources until the byte start has been sampled
			i_sfs_host_model.tick(4);
			exp = nxt;
		end
		end_frame();
		$display("stream test done");
	endtask : test_stream
	task test_abort();
		logic [7:0] q;
		write_lock(1'h0);
		ready_busy_flag = 1'h1;
		status_src = 13'h0a5c;
		i_sfs_host_model.select(8'h05);
		i_sfs_host_model.xfer(8'haa, 3, q);
		check(q, {1'h0, status_src.byte1_misc[6:5], 5'h00});
		end_frame();
		$display("abort test done");
	endtask : test_abort
	task test_refused();
		logic [7:0] q;
		i_sfs_host_model.select(8'h06);
		i_sfs_host_model.xfer(8'h55, 8, q);
		check({7'h0, so_oe_n}, 8'h01);
		end_frame();
		$display("refused test done");
	endtask : test_refused
	task test_reset();
		check({6'h0, so_oe_n, protection_regs_locked}, 8'h02);
		$display("reset test done");
	endtask : test_reset
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'h0;
		test_reset();
		test_stream();
		test_abort();
		test_refused();
		finish_test();
	end
endmodule : sfs_status_read_tb
